// ---- gpc_pkg.sv ----
// Constants shared by the three-port GPIO block
package gpc_pkg;

  // ----------------------------------------
  // Port widths and pin vector layout
  // ----------------------------------------
  localparam int PA_W = 6;
  localparam int PB_W = 8;
  localparam int PC_W = 8;
  localparam int PIN_W = 22;
  localparam int PA_LO = 0;
  localparam int PB_LO = 6;
  localparam int PC_LO = 14;

  // ----------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_PA = 8'h05;
  localparam logic [7:0] IDX_PB = 8'h06;
  localparam logic [7:0] IDX_PC = 8'h07;
  localparam logic [7:0] IDX_INTC = 8'h0b;
  localparam logic [7:0] IDX_OPT = 8'h81;
  localparam logic [7:0] IDX_DIRA = 8'h85;
  localparam logic [7:0] IDX_DIRB = 8'h86;
  localparam logic [7:0] IDX_DIRC = 8'h87;
  localparam logic [7:0] IDX_ADC = 8'h9f;
  localparam logic [7:0] IDX_SPEC = 8'ha0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int OPT_PU_DIS = 7;
  localparam int OPT_EDGE = 6;
  localparam int INTC_CHG = 0;
  localparam int INTC_EXT = 1;
  localparam int SPEC_LVP = 0;
  localparam int PA_TMR = 4;
  localparam int PA_SS = 5;
  localparam int PB_INT = 0;
  localparam int PB_LVP = 3;
  localparam int CHG_LO = 4;
  localparam int CHG_W = 4;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] OPT_RST = 8'hff;
  localparam logic [5:0] DIRA_RST = 6'h3f;
  localparam logic [7:0] DIRB_RST = 8'hff;
  localparam logic [7:0] DIRC_RST = 8'hff;
  localparam logic [7:0] ADC_RST = 8'h00;
  localparam logic [7:0] ADC_MASK = 8'h8f;
  localparam logic [2:0] PCFG_DIGITAL = 3'h3;
  localparam logic [5:0] PA_ANA_MASK = 6'h2f;
  localparam logic [5:0] PA_OD_MASK = 6'h10;
  localparam logic [7:0] PB_LVP_MASK = 8'h08;

endpackage

// ---- gpc_top.sv ----
// Three-port GPIO block with change detect, edge input and Wishbone slave
`timescale 1ns/10ps

module gpc_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Port A pins
  input wire logic [5:0] pa_in_i,
  output logic [5:0] pa_out_o,
  output logic [5:0] pa_oe_o,
  // Port B pins
  input wire logic [7:0] pb_in_i,
  output logic [7:0] pb_out_o,
  output logic [7:0] pb_oe_o,
  output logic [7:0] pb_pullup_o,
  // Port C pins
  input wire logic [7:0] pc_in_i,
  output logic [7:0] pc_out_o,
  output logic [7:0] pc_oe_o,
  // Port C peripheral overrides
  input wire logic [7:0] pc_periph_sel_i,
  input wire logic [7:0] pc_periph_out_i,
  input wire logic [7:0] pc_periph_oe_i,
  // Alternate functions and events
  output logic [7:0] pc_pin_o,
  output logic timer_clock_o,
  output logic serial_slave_select_n_o,
  output logic [3:0] analog_pin_select_o,
  output logic lowvolt_program_mode_o,
  output logic port_change_flag_o,
  output logic ext_irq_flag_o,
  output logic wake_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [21:0] s1;
    logic [21:0] s2;
    logic [21:0] s3;
    logic [21:0] pin;
    logic [5:0] pa_lat;
    logic [7:0] pb_lat;
    logic [7:0] pc_lat;
    logic [7:0] opt;
    logic [5:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] adc;
    logic lowvolt_program_mode;
    logic [3:0] pb_old;
    logic chg;
    logic ext;
    logic rb0_prev;
    logic [5:0] pa_out;
    logic [5:0] pa_oe;
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    logic [7:0] pb_pu;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
    logic wake;
  } gpc_state_s;

  gpc_state_s st;
  gpc_state_s next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] idx;
    logic req;
    logic wr;
    logic [5:0] pa_v;
    logic [7:0] pb_v;
    logic [7:0] pc_v;
    logic [5:0] ana;
    logic [3:0] mism;
    logic rb0;
    logic edge_hit;
    logic [7:0] rd;
    idx = adr_i[9:2];
    req = cyc_i && stb_i && !st.ack;
    wr = st.ack && cyc_i && stb_i && we_i && sel_i[0];
    pa_v = st.pin[gpc_pkg::PA_LO +: gpc_pkg::PA_W];
    pb_v = st.pin[gpc_pkg::PB_LO +: gpc_pkg::PB_W];
    pc_v = st.pin[gpc_pkg::PC_LO +: gpc_pkg::PC_W];
    ana = (st.adc[3:1] == gpc_pkg::PCFG_DIGITAL) ? 6'h00 : gpc_pkg::PA_ANA_MASK;
    mism = (pb_v[gpc_pkg::CHG_LO +: gpc_pkg::CHG_W] ^ st.pb_old)
      & st.dir_b[gpc_pkg::CHG_LO +: gpc_pkg::CHG_W];
    rb0 = pb_v[gpc_pkg::PB_INT];
    edge_hit = st.opt[gpc_pkg::OPT_EDGE] ? (rb0 && !st.rb0_prev)
      : (!rb0 && st.rb0_prev);
    rd = 8'h00;
    next_st = st;

    // Pin synchronisers; a change counts once stages two and three agree
    next_st.s1 = {pc_in_i, pb_in_i, pa_in_i};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.pin = (st.s2 & st.s3) | (st.pin & (st.s2 ^ st.s3));

    // Bus answer, one cycle after the request
    next_st.ack = req;
    if (req)
    begin
      case (idx)
        gpc_pkg::IDX_PA: rd = {2'h0, pa_v & ~ana};
        gpc_pkg::IDX_PB: rd = pb_v;
        gpc_pkg::IDX_PC: rd = pc_v;
        gpc_pkg::IDX_INTC: rd = {6'h00, st.ext, st.chg};
        gpc_pkg::IDX_OPT: rd = st.opt;
        gpc_pkg::IDX_DIRA: rd = {2'h0, st.dir_a};
        gpc_pkg::IDX_DIRB: rd = st.dir_b;
        gpc_pkg::IDX_DIRC: rd = st.dir_c;
        gpc_pkg::IDX_ADC: rd = st.adc;
        gpc_pkg::IDX_SPEC: rd = {7'h00, st.lowvolt_program_mode};
        default: rd = 8'h00;
      endcase
      next_st.dat = {24'h000000, rd};
      if (idx == gpc_pkg::IDX_PB)
      begin
        next_st.pb_old = pb_v[gpc_pkg::CHG_LO +: gpc_pkg::CHG_W];
      end
    end

    // Register writes, taken at the acknowledged edge
    if (wr)
    begin
      case (idx)
        gpc_pkg::IDX_PA: next_st.pa_lat = dat_i[5:0];
        gpc_pkg::IDX_PB: next_st.pb_lat = dat_i[7:0];
        gpc_pkg::IDX_PC: next_st.pc_lat = dat_i[7:0];
        gpc_pkg::IDX_INTC:
        begin
          next_st.chg = dat_i[gpc_pkg::INTC_CHG];
          next_st.ext = dat_i[gpc_pkg::INTC_EXT];
        end
        gpc_pkg::IDX_OPT: next_st.opt = dat_i[7:0];
        gpc_pkg::IDX_DIRA: next_st.dir_a = dat_i[5:0];
        gpc_pkg::IDX_DIRB: next_st.dir_b = dat_i[7:0];
        gpc_pkg::IDX_DIRC: next_st.dir_c = dat_i[7:0];
        gpc_pkg::IDX_ADC: next_st.adc = dat_i[7:0] & gpc_pkg::ADC_MASK;
        gpc_pkg::IDX_SPEC: next_st.lowvolt_program_mode = dat_i[gpc_pkg::SPEC_LVP];
        default: next_st.adc = st.adc;
      endcase
    end

    // Event flags; a set wins over a clear in the same cycle
    if (|mism)
    begin
      next_st.chg = 1'b1;
    end
    if (edge_hit)
    begin
      next_st.ext = 1'b1;
    end
    next_st.rb0_prev = rb0;
    next_st.wake = |mism;

    // Pin drivers
    next_st.pa_out = st.pa_lat & ~gpc_pkg::PA_OD_MASK;
    next_st.pa_oe = ~st.dir_a & ~(st.pa_lat & gpc_pkg::PA_OD_MASK);
    next_st.pb_out = st.pb_lat;
    next_st.pb_oe = ~st.dir_b & ~({8{st.lowvolt_program_mode}} & gpc_pkg::PB_LVP_MASK);
    next_st.pb_pu = {8{~st.opt[gpc_pkg::OPT_PU_DIS]}} & st.dir_b;
    next_st.pc_out = (pc_periph_sel_i & pc_periph_out_i)
      | (~pc_periph_sel_i & st.pc_lat);
    next_st.pc_oe = (pc_periph_sel_i & pc_periph_oe_i)
      | (~pc_periph_sel_i & ~st.dir_c);

    // Reset values
    if (rst_i)
    begin
      next_st = '0;
      next_st.opt = gpc_pkg::OPT_RST;
      next_st.dir_a = gpc_pkg::DIRA_RST;
      next_st.dir_b = gpc_pkg::DIRB_RST;
      next_st.dir_c = gpc_pkg::DIRC_RST;
      next_st.adc = gpc_pkg::ADC_RST;
      next_st.lowvolt_program_mode = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ack_o = st.ack;
  assign dat_o = st.dat;
  assign pa_out_o = st.pa_out;
  assign pa_oe_o = st.pa_oe;
  assign pb_out_o = st.pb_out;
  assign pb_oe_o = st.pb_oe;
  assign pb_pullup_o = st.pb_pu;
  assign pc_out_o = st.pc_out;
  assign pc_oe_o = st.pc_oe;
  assign pc_pin_o = st.pin[gpc_pkg::PC_LO +: gpc_pkg::PC_W];
  assign timer_clock_o = st.pin[gpc_pkg::PA_LO + gpc_pkg::PA_TMR];
  assign serial_slave_select_n_o = st.pin[gpc_pkg::PA_LO + gpc_pkg::PA_SS];
  assign analog_pin_select_o = st.adc[3:0];
  assign lowvolt_program_mode_o = st.lowvolt_program_mode;
  assign port_change_flag_o = st.chg;
  assign ext_irq_flag_o = st.ext;
  assign wake_o = st.wake;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ack_single_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_ack_after_req: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered next cycle");

  a_pb_drive_dir: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pb_oe_o[0] == !$past(st.dir_b[0])))
    else $error("port B bit 0 driver does not follow direction");

  a_pullup_out_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 ((pb_pullup_o & ~$past(st.dir_b)) == 8'h00))
    else $error("pull-up on an output pin");

  a_pullup_por_off: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> (pb_pullup_o == 8'h00) ##1 (pb_pullup_o == 8'h00))
    else $error("pull-up active after reset");

  a_change_flag_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (|((st.pin[13:10] ^ st.pb_old) & st.dir_b[7:4])) |=> (port_change_flag_o && wake_o))
    else $error("mismatch did not set change flag");

  a_ra4_open_drain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pa_out_o[4] == 1'b0)
    else $error("open-drain pin driven high");

  a_lvp_bit3_free: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st.lowvolt_program_mode && $stable(st.lowvolt_program_mode)) |=> !pb_oe_o[3])
    else $error("bit 3 driven in programming mode");

  a_pc_override_oe: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pc_oe_o == (($past(pc_periph_sel_i) & $past(pc_periph_oe_i))
      | (~$past(pc_periph_sel_i) & ~$past(st.dir_c)))))
    else $error("port C enable does not follow override");

  a_port_a_pin_latch_unused_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && (adr_i[9:2] == gpc_pkg::IDX_PA || adr_i[9:2] == gpc_pkg::IDX_DIRA))
      |-> (dat_o[31:6] == 26'h0000000))
    else $error("port A unused bits not zero");

  a_pb_out_latch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pb_out_o == $past(st.pb_lat)))
    else $error("port B output does not follow latch");

  a_pullup_global: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pb_pullup_o == ({8{!$past(st.opt[gpc_pkg::OPT_PU_DIS])}} & $past(st.dir_b))))
    else $error("pull-ups do not follow option bit");

  a_pc_out_select: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pc_out_o == (($past(pc_periph_sel_i) & $past(pc_periph_out_i))
      | (~$past(pc_periph_sel_i) & $past(st.pc_lat)))))
    else $error("port C output does not follow select");

  a_change_out_masked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!port_change_flag_o && !(|((st.pin[13:10] ^ st.pb_old) & st.dir_b[7:4]))
      && !(ack_o && we_i && sel_i[0] && (adr_i[9:2] == gpc_pkg::IDX_INTC)
      && dat_i[gpc_pkg::INTC_CHG])) |=> !port_change_flag_o)
    else $error("change flag set without enabled mismatch");

  a_wake_flag_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_o |-> port_change_flag_o)
    else $error("wake without change flag");

  a_ext_rise_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($rose(st.pin[gpc_pkg::PB_LO + gpc_pkg::PB_INT]) && st.opt[gpc_pkg::OPT_EDGE])
      |=> ext_irq_flag_o)
    else $error("rising edge did not set edge flag");

  a_ext_fall_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($fell(st.pin[gpc_pkg::PB_LO + gpc_pkg::PB_INT]) && !st.opt[gpc_pkg::OPT_EDGE])
      |=> ext_irq_flag_o)
    else $error("falling edge did not set edge flag");

  a_lvp_reset_on: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> lowvolt_program_mode_o)
    else $error("programming mode off after reset");

  a_port_a_pin_latch_analog_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && !we_i && (adr_i[9:2] == gpc_pkg::IDX_PA) && ($past(st.adc[3:1]) != gpc_pkg::PCFG_DIGITAL))
      |-> ((dat_o[5:0] & gpc_pkg::PA_ANA_MASK) == 6'h00))
    else $error("analog port A pin read nonzero");

  a_port_b_pin_latch_read_pins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && !we_i && (adr_i[9:2] == gpc_pkg::IDX_PB))
      |-> (dat_o[7:0] == $past(st.pin[gpc_pkg::PB_LO +: gpc_pkg::PB_W])))
    else $error("port B read does not return pins");

  a_pa_drive_dir: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 (pa_oe_o == (~$past(st.dir_a) & ~($past(st.pa_lat) & gpc_pkg::PA_OD_MASK))))
    else $error("port A driver enable wrong");

  a_flag_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ack_o && !we_i && (adr_i[9:2] == gpc_pkg::IDX_INTC))
      |-> (dat_o[7:0] == {6'h00, $past(st.ext), $past(st.chg)}))
    else $error("flag readback wrong");

endmodule

// ---- gpc_board.sv ----
// Board model giving the pin levels of the three ports
`timescale 1ns/10ps

module gpc_board
(
  // Clock
  input wire logic clk_i,
  // Design drive
  input wire logic [5:0] pa_out_i,
  input wire logic [5:0] pa_oe_i,
  input wire logic [7:0] pb_out_i,
  input wire logic [7:0] pb_oe_i,
  input wire logic [7:0] pb_pu_i,
  input wire logic [7:0] pc_out_i,
  input wire logic [7:0] pc_oe_i,
  // Board drive
  input wire logic [5:0] a_val_i,
  input wire logic [7:0] b_val_i,
  input wire logic [7:0] b_en_i,
  input wire logic [7:0] c_val_i,
  // Pin levels
  output logic [5:0] pa_o,
  output logic [7:0] pb_o,
  output logic [7:0] pc_o
);
  logic flt = 1'b0;

  // Released unpulled pins wander
  always_ff @(posedge clk_i) flt <= ~flt;
  assign pa_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & a_val_i);
  assign pb_o = (pb_oe_i & pb_out_i) | (~pb_oe_i & b_en_i & b_val_i)
    | (~pb_oe_i & ~b_en_i & (pb_pu_i | {8{flt}}));
  assign pc_o = (pc_oe_i & pc_out_i) | (~pc_oe_i & c_val_i);
endmodule

// ---- gpc_top_tb.sv ----
// Self-checking bench for the three-port GPIO block
`timescale 1ns/10ps

module gpc_top_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic ack_o, timer_clock_o, serial_slave_select_n_o, lowvolt_program_mode_o;
  logic port_change_flag_o, ext_irq_flag_o, wake_o;
  logic [3:0] analog_pin_select_o;
  logic [5:0] pa_in_i, pa_out_o, pa_oe_o, p, av = '0;
  logic [7:0] pb_in_i, pb_out_o, pb_oe_o, pb_pullup_o, pc_in_i, pc_out_o, pc_oe_o;
  logic [7:0] pc_pin_o, e, o, pc_periph_sel_i = '0, pc_periph_out_i = '0;
  logic [7:0] pc_periph_oe_i = '0, bv = '0, ben = 8'hff, cv = '0;
  logic [7:0] ix[7] = '{8'h81, 8'h85, 8'h86, 8'h87, 8'h9f, 8'ha0, 8'h3f};
  logic [15:0] rnd = 16'h8f91;
  int m[256];
  int err_total = 0;
  int checked = 0;

  gpc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pa_in_i(pa_in_i), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o), .pb_in_i(pb_in_i),
    .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o), .pb_pullup_o(pb_pullup_o), .pc_in_i(pc_in_i),
    .pc_out_o(pc_out_o), .pc_oe_o(pc_oe_o), .pc_periph_sel_i(pc_periph_sel_i),
    .pc_periph_out_i(pc_periph_out_i), .pc_periph_oe_i(pc_periph_oe_i),
    .pc_pin_o(pc_pin_o), .timer_clock_o(timer_clock_o),
    .serial_slave_select_n_o(serial_slave_select_n_o),
    .analog_pin_select_o(analog_pin_select_o),
    .lowvolt_program_mode_o(lowvolt_program_mode_o),
    .port_change_flag_o(port_change_flag_o), .ext_irq_flag_o(ext_irq_flag_o),
    .wake_o(wake_o));
  gpc_board board (.clk_i(clk_i), .pa_out_i(pa_out_o), .pa_oe_i(pa_oe_o), .pb_out_i(pb_out_o),
    .pb_oe_i(pb_oe_o), .pb_pu_i(pb_pullup_o), .pc_out_i(pc_out_o), .pc_oe_i(pc_oe_o),
    .a_val_i(av), .b_val_i(bv), .b_en_i(ben), .c_val_i(cv), .pa_o(pa_in_i),
    .pb_o(pb_in_i), .pc_o(pc_in_i));

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // ----
  // Model and bus helpers
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int wmask(input logic [7:0] i);
    case (i)
      8'h05, 8'h85: return 8'h3f;
      8'h0b: return 8'h03;
      8'h9f: return 8'h8f;
      8'ha0: return 8'h01;
      8'h06, 8'h07, 8'h81, 8'h86, 8'h87: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [5:0] pa_pins();
    logic [5:0] oe;
    oe = ~m[8'h85][5:0];
    oe[4] = oe[4] & ~m[8'h05][4];
    return (oe & m[8'h05][5:0] & 6'h2f) | (~oe & av);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    if (w) m[i] = d & wmask(i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200us;
    err_total++;
    report_and_stop();
  end

  // ----
  // Scenarios
  // ----
  initial
  begin
    for (int k = 0; k < 256; k++) m[k] = 0;
    m[8'h81] = 8'hff;
    m[8'h85] = 8'h3f;
    m[8'h86] = 8'hff;
    m[8'h87] = 8'hff;
    m[8'ha0] = 8'h01;
    tick(6);
    rst_i <= 1'b0;
    tick(6);
    chk(pb_pullup_o, 8'h00);
    chk(lowvolt_program_mode_o, 1'b1);
    foreach (ix[k])
    begin
      wb(1'b0, ix[k], 8'h00);
      chk(rd, m[ix[k]]);
    end
    $display("Test reset values done");
    rnd = lfsr(rnd);
    wb(1'b1, 8'h06, rnd[7:0]);
    wb(1'b1, 8'h86, 8'h00);
    tick(2);
    chk(pb_oe_o, 8'hf7);
    chk(pb_out_o, rnd[7:0]);
    wb(1'b1, 8'ha0, 8'h00);
    tick(6);
    chk(pb_oe_o, 8'hff);
    wb(1'b0, 8'h06, 8'h00);
    chk(rd, rnd[7:0]);
    wb(1'b1, 8'h81, 8'h7f);
    wb(1'b1, 8'h86, 8'h0f);
    ben <= 8'h00;
    tick(6);
    chk(pb_pullup_o, 8'h0f);
    wb(1'b0, 8'h06, 8'h00);
    chk(rd, {rnd[7:4], 4'hf});
    wb(1'b1, 8'h81, 8'hff);
    ben <= 8'hff;
    tick(2);
    chk(pb_pullup_o, 8'h00);
    $display("Test port B drive done");
    wb(1'b1, 8'h86, 8'hff);
    tick(6);
    wb(1'b0, 8'h06, 8'h00);
    wb(1'b1, 8'h0b, 8'h00);
    tick(2);
    chk(port_change_flag_o, 1'b0);
    bv <= 8'h20;
    tick(6);
    chk(port_change_flag_o, 1'b1);
    chk(wake_o, 1'b1);
    wb(1'b1, 8'h0b, 8'h00);
    tick(2);
    chk(port_change_flag_o, 1'b1);
    wb(1'b0, 8'h06, 8'h00);
    chk(rd, 8'h20);
    wb(1'b1, 8'h0b, 8'h00);
    tick(2);
    chk(port_change_flag_o, 1'b0);
    chk(wake_o, 1'b0);
    bv <= 8'h2e;
    wb(1'b1, 8'h06, 8'h80);
    wb(1'b1, 8'h86, 8'h7f);
    tick(6);
    chk(port_change_flag_o, 1'b0);
    for (int k = 1; k >= 0; k--)
    begin
      wb(1'b1, 8'h81, k ? 8'hff : 8'hbf);
      wb(1'b1, 8'h0b, 8'h00);
      tick(2);
      chk(ext_irq_flag_o, 1'b0);
      bv[0] <= ~bv[0];
      tick(6);
      chk(ext_irq_flag_o, 1'b1);
    end
    $display("Test port B events done");
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      e = k[0] ? 8'h06 : 8'h00;
      av <= rnd[5:0];
      wb(1'b1, 8'h05, {2'b00, rnd[13:8]});
      wb(1'b1, 8'h85, {2'b00, rnd[11:6]});
      wb(1'b1, 8'h9f, e);
      tick(6);
      p = pa_pins();
      wb(1'b0, 8'h05, 8'h00);
      chk(rd, {2'b00, p & (k[0] ? 6'h3f : 6'h10)});
      chk(pa_out_o[4], 1'b0);
      chk(timer_clock_o, p[4]);
      chk(serial_slave_select_n_o, p[5]);
      chk(analog_pin_select_o, e[3:0]);
      o = {2'b00, ~m[8'h85][5:0] & ~(m[8'h05][5:0] & 6'h10)};
      chk(pa_oe_o, o);
    end
    $display("Test port A done");
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      pc_periph_sel_i <= rnd[7:0];
      pc_periph_out_i <= rnd[15:8];
      cv <= rnd[11:4];
      rnd = lfsr(rnd);
      pc_periph_oe_i <= rnd[7:0];
      wb(1'b1, 8'h87, rnd[15:8]);
      wb(1'b1, 8'h07, rnd[10:3]);
      tick(6);
      e = (pc_periph_sel_i & pc_periph_oe_i) | (~pc_periph_sel_i & ~m[8'h87][7:0]);
      o = (pc_periph_sel_i & pc_periph_out_i) | (~pc_periph_sel_i & m[8'h07][7:0]);
      chk(pc_oe_o, e);
      chk(pc_out_o, o);
      chk(pc_pin_o, (e & o) | (~e & cv));
      wb(1'b0, 8'h07, 8'h00);
      chk(rd, (e & o) | (~e & cv));
    end
    $display("Test port C done");
    report_and_stop();
  end
endmodule
